/* File: verilog/ofd_pkg.sv */
// Package for the operand field decoder: field positions, widths, enums, carriers.
// Assumes one core clock; instruction words arrive from fetch logic on that clock.
// Summary of operation
// - a bit 0 selects access RAM, ignoring bank select; 1 uses bank select.
// - d bit 0 writes result to accumulator; 1 writes back to file register.
// - bit instructions carry a three-bit bit number 0 to 7 of the byte.
// - file field is 8-bit address, or 2-bit indirect pointer designator.
// - register moves carry 12-bit source and destination addresses, no banking.
// - literal constant is 8, 12 or 20 bits wide by instruction.
// - table mode selects no change, post-increment, post-decrement or pre-increment.
// - relative branch offsets are two's complement; call and goto use a direct 20-bit target.
// - fast bit 1 saves or restores shadow registers; 0 leaves them untouched.
// - program table pointer is 21 bits wide, addressing program memory.
// - don't-care instruction bits are ignored whatever their value.
// - indexed instructions carry a 7-bit source offset; destination is a 7-bit offset or 12-bit address.
// - five status flags kept: carry, digit carry, zero, overflow, negative.
// - second word has four ones on top; executed alone it is a no-operation.
// - one instruction cycle spans four oscillator periods, four phases.
package ofd_pkg;

  // ==========================================================
  // widths
  localparam int WORD_W  = 16;
  localparam int BANK_W  = 4;
  localparam int F8_W    = 8;
  localparam int F12_W   = 12;
  localparam int BIT_W   = 3;
  localparam int PTR_W   = 2;
  localparam int LIT_W   = 20;
  localparam int TBLP_W  = 21;
  localparam int PC_W    = 21;
  localparam int OFS_W   = 7;
  localparam int BRA11_W = 11;
  localparam int BR8_W   = 8;
  localparam int LFSR_HI_W = 4;

  // ==========================================================
  // field positions
  localparam int A_POS      = 8;
  localparam int D_POS      = 9;
  localparam int BIT_LSB    = 9;
  localparam int PTR_LSB    = 4;
  localparam int CALL_S_POS = 8;
  localparam int RET_S_POS  = 0;
  localparam int TAG_LSB    = 12;
  localparam int TBL_MODE_W = 2;

  // ==========================================================
  // constants
  localparam logic [3:0]       SECOND_TAG = 4'hF;
  localparam logic [F8_W-1:0]  BIT_ONE    = 8'h01;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    OFD_FMT_NOP   = 4'h0,
    OFD_FMT_BYTE  = 4'h1,
    OFD_FMT_BIT   = 4'h2,
    OFD_FMT_LIT8  = 4'h3,
    OFD_FMT_LFSR  = 4'h4,
    OFD_FMT_MOVFF = 4'h5,
    OFD_FMT_GOTO  = 4'h6,
    OFD_FMT_CALL  = 4'h7,
    OFD_FMT_BRA11 = 4'h8,
    OFD_FMT_BR8   = 4'h9,
    OFD_FMT_TBL   = 4'hA,
    OFD_FMT_RET   = 4'hB,
    OFD_FMT_MOVSF = 4'hC,
    OFD_FMT_MOVSS = 4'hD
  } ofd_fmt_t;

  typedef enum logic [1:0] {
    OFD_LIT_NONE = 2'h0,
    OFD_LIT_8    = 2'h1,
    OFD_LIT_12   = 2'h2,
    OFD_LIT_20   = 2'h3
  } ofd_lit_w_t;

  typedef enum logic [1:0] {
    OFD_TBL_SAME     = 2'h0,
    OFD_TBL_POST_INC = 2'h1,
    OFD_TBL_POST_DEC = 2'h2,
    OFD_TBL_PRE_INC  = 2'h3
  } ofd_tbl_mode_t;

  typedef enum logic [3:0] {
    OFD_Q1 = 4'h1,
    OFD_Q2 = 4'h2,
    OFD_Q3 = 4'h4,
    OFD_Q4 = 4'h8
  } ofd_phase_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
    logic ov;
    logic n;
  } ofd_status_t;

  typedef struct packed {
    ofd_fmt_t          fmt;
    logic              is_nop;
    logic              access_ram;
    logic [BANK_W-1:0] bank;
    logic              to_file;
    logic [BIT_W-1:0]  bit_num;
    logic [F8_W-1:0]   bit_mask;
    logic [F8_W-1:0]   file_addr;
    logic [PTR_W-1:0]  ptr_sel;
    logic [F12_W-1:0]  src_addr;
    logic [F12_W-1:0]  dst_addr;
    logic [LIT_W-1:0]  literal;
    ofd_lit_w_t        lit_width;
    ofd_tbl_mode_t     tbl_mode;
    logic [TBLP_W-1:0] tbl_addr;
    logic [TBLP_W-1:0] tbl_ptr_next;
    logic              rel_branch;
    logic [PC_W-1:0]   branch_offset;
    logic [LIT_W-1:0]  target;
    logic              fast_shadow;
    logic [OFS_W-1:0]  src_ofs;
    logic [OFS_W-1:0]  dst_ofs;
  } ofd_fields_t;

endpackage

/* File: verilog/ofd_ptr_step.sv */
// Table pointer stepper: access address and updated pointer for one mode.
// Assumes the caller registers the results; purely combinational.
`timescale 1ns/1ps
module ofd_ptr_step
#(
  parameter int W = 21
)
(
  input  wire logic [W-1:0]          ptr_i,
  input  wire ofd_pkg::ofd_tbl_mode_t mode_i,
  output logic      [W-1:0]          access_o,
  output logic      [W-1:0]          next_o
);
  import ofd_pkg::*;

  // ==========================================================
  // step arithmetic
  wire [W-1:0] ptr_inc = ptr_i + W'(1);
  wire [W-1:0] ptr_dec = ptr_i - W'(1);
  wire         pre     = (mode_i == OFD_TBL_PRE_INC);

  assign access_o = pre ? ptr_inc : ptr_i;
  assign next_o   = (mode_i == OFD_TBL_SAME)     ? ptr_i   :
                    (mode_i == OFD_TBL_POST_DEC) ? ptr_dec : ptr_inc;
endmodule

/* File: verilog/ofd_decoder.sv */
// Operand field decoder: splits fetched instruction words into datapath fields.
// Assumes fetch logic presents each word with a format class at phase one,
// on the core clock, and holds the bank select and table pointer values steady.
`timescale 1ns/1ps
module ofd_decoder
#(
  parameter int OSC_DIV = 1
)
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          instr_valid_i,
  input  wire logic [ofd_pkg::WORD_W-1:0]    instr_word_i,
  input  wire ofd_pkg::ofd_fmt_t             instr_fmt_i,
  input  wire logic [ofd_pkg::BANK_W-1:0]    bank_select_reg_i,
  input  wire logic [ofd_pkg::TBLP_W-1:0]    program_table_pointer_i,
  input  wire ofd_pkg::ofd_status_t          alu_flags_i,
  input  wire ofd_pkg::ofd_status_t          alu_flag_we_i,
  output ofd_pkg::ofd_fields_t               fields_o,
  output logic                               fields_valid_o,
  output ofd_pkg::ofd_phase_t                phase_o,
  output logic                               second_wait_o,
  output ofd_pkg::ofd_status_t               status_o
);
  import ofd_pkg::*;

  // ==========================================================
  // oscillator period enable
  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

  logic [DIV_W-1:0] div_cnt;
  wire              osc_tick = (div_cnt == DIV_LAST);

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_cnt <= '0;
    else
      div_cnt <= osc_tick ? '0 : div_cnt + DIV_W'(1);
  end

  // ==========================================================
  // four phase instruction cycle
  ofd_phase_t next_phase;

  always_comb
  begin
    case (phase_o)
      OFD_Q1:  next_phase = OFD_Q2;
      OFD_Q2:  next_phase = OFD_Q3;
      OFD_Q3:  next_phase = OFD_Q4;
      OFD_Q4:  next_phase = OFD_Q1;
      default: next_phase = OFD_Q1;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      phase_o <= OFD_Q1;
    else if (osc_tick)
      phase_o <= next_phase;
  end

  wire take_tick    = osc_tick && (phase_o == OFD_Q1);
  wire publish_tick = osc_tick && (phase_o == OFD_Q4);

  // ==========================================================
  // word capture and pairing
  logic [WORD_W-1:0] word1;
  logic [WORD_W-1:0] word2;
  ofd_fmt_t          fmt;
  logic              ready;

  wire has_tag  = (instr_word_i[WORD_W-1:TAG_LSB] == SECOND_TAG);
  wire two_word = (instr_fmt_i == OFD_FMT_MOVFF) || (instr_fmt_i == OFD_FMT_GOTO) ||
                  (instr_fmt_i == OFD_FMT_CALL)  || (instr_fmt_i == OFD_FMT_LFSR) ||
                  (instr_fmt_i == OFD_FMT_MOVSF) || (instr_fmt_i == OFD_FMT_MOVSS);
  wire take     = take_tick && instr_valid_i;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word1         <= WORD_ZERO;
      word2         <= WORD_ZERO;
      fmt           <= OFD_FMT_NOP;
      ready         <= 1'b0;
      second_wait_o <= 1'b0;
    end
    else if (take && second_wait_o)
    begin
      word2         <= instr_word_i;
      second_wait_o <= 1'b0;
      ready         <= 1'b1;
      if (!has_tag)
        fmt <= OFD_FMT_NOP;
    end
    else if (take && has_tag)
    begin
      word1 <= instr_word_i;
      word2 <= WORD_ZERO;
      fmt   <= OFD_FMT_NOP;
      ready <= 1'b1;
    end
    else if (take)
    begin
      word1         <= instr_word_i;
      word2         <= WORD_ZERO;
      fmt           <= instr_fmt_i;
      second_wait_o <= two_word;
      ready         <= !two_word;
    end
    else if (publish_tick)
      ready <= 1'b0;
  end

  // ==========================================================
  // format selects
  wire is_byte  = (fmt == OFD_FMT_BYTE);
  wire is_bit   = (fmt == OFD_FMT_BIT);
  wire is_lit8  = (fmt == OFD_FMT_LIT8);
  wire is_lfsr  = (fmt == OFD_FMT_LFSR);
  wire is_movff = (fmt == OFD_FMT_MOVFF);
  wire is_goto  = (fmt == OFD_FMT_GOTO);
  wire is_call  = (fmt == OFD_FMT_CALL);
  wire is_bra11 = (fmt == OFD_FMT_BRA11);
  wire is_br8   = (fmt == OFD_FMT_BR8);
  wire is_tbl   = (fmt == OFD_FMT_TBL);
  wire is_ret   = (fmt == OFD_FMT_RET);
  wire is_movsf = (fmt == OFD_FMT_MOVSF);
  wire is_movss = (fmt == OFD_FMT_MOVSS);
  wire banked   = is_byte || is_bit;

  // ==========================================================
  // field extraction
  wire                a_bit      = banked && word1[A_POS];
  wire                access_ram = banked && !word1[A_POS];
  wire [BANK_W-1:0]   bank       = a_bit ? bank_select_reg_i : '0;
  wire                to_file    = is_byte && word1[D_POS];
  wire [BIT_W-1:0]    bit_num    = is_bit ? word1[BIT_LSB +: BIT_W] : '0;
  wire [F8_W-1:0]     bit_mask   = is_bit ? (BIT_ONE << bit_num) : '0;
  wire [F8_W-1:0]     file_addr  = banked ? word1[F8_W-1:0] : '0;
  wire [PTR_W-1:0]    ptr_sel    = is_lfsr ? word1[PTR_LSB +: PTR_W] : '0;
  wire [F12_W-1:0]    src_addr   = is_movff ? word1[F12_W-1:0] : '0;
  wire [F12_W-1:0]    dst_addr   = (is_movff || is_movsf) ? word2[F12_W-1:0] : '0;
  wire [LIT_W-1:0]    lit_long   = {word2[F12_W-1:0], word1[F8_W-1:0]};
  wire [LIT_W-1:0]    lit_k12    = LIT_W'({word1[LFSR_HI_W-1:0], word2[F8_W-1:0]});
  wire [LIT_W-1:0]    lit_k8     = LIT_W'(word1[F8_W-1:0]);
  wire                long_addr  = is_goto || is_call;

  wire [LIT_W-1:0] literal = is_lit8   ? lit_k8  :
                             is_lfsr   ? lit_k12 :
                             long_addr ? lit_long : '0;
  ofd_lit_w_t lit_width;
  assign lit_width = is_lit8   ? OFD_LIT_8  :
                     is_lfsr   ? OFD_LIT_12 :
                     long_addr ? OFD_LIT_20 : OFD_LIT_NONE;

  ofd_tbl_mode_t tbl_mode;
  assign tbl_mode = is_tbl ? ofd_tbl_mode_t'(word1[TBL_MODE_W-1:0]) : OFD_TBL_SAME;

  logic [TBLP_W-1:0] tbl_addr;
  logic [TBLP_W-1:0] tbl_next;

  ofd_ptr_step #(.W(TBLP_W)) u_ptr_step
  (
    .ptr_i    (program_table_pointer_i),
    .mode_i   (tbl_mode),
    .access_o (tbl_addr),
    .next_o   (tbl_next)
  );

  wire [PC_W-1:0] ofs11 = {{(PC_W-BRA11_W){word1[BRA11_W-1]}}, word1[BRA11_W-1:0]};
  wire [PC_W-1:0] ofs8  = {{(PC_W-BR8_W){word1[BR8_W-1]}}, word1[BR8_W-1:0]};
  wire            rel   = is_bra11 || is_br8;
  wire [PC_W-1:0] branch_offset = is_bra11 ? ofs11 : is_br8 ? ofs8 : '0;
  wire [LIT_W-1:0] target = long_addr ? lit_long : '0;

  wire fast_shadow = (is_call && word1[CALL_S_POS]) || (is_ret && word1[RET_S_POS]);

  // in the second word only the four tag bits on top and the low offset bits count; the rest are don't-care
  wire [OFS_W-1:0] src_ofs = (is_movsf || is_movss) ? word1[OFS_W-1:0] : '0;
  wire [OFS_W-1:0] dst_ofs = is_movss ? word2[OFS_W-1:0] : '0;

  ofd_fields_t next_fields;
  assign next_fields = '{
    fmt:           fmt,
    is_nop:        (fmt == OFD_FMT_NOP),
    access_ram:    access_ram,
    bank:          bank,
    to_file:       to_file,
    bit_num:       bit_num,
    bit_mask:      bit_mask,
    file_addr:     file_addr,
    ptr_sel:       ptr_sel,
    src_addr:      src_addr,
    dst_addr:      dst_addr,
    literal:       literal,
    lit_width:     lit_width,
    tbl_mode:      tbl_mode,
    tbl_addr:      is_tbl ? tbl_addr : '0,
    tbl_ptr_next:  is_tbl ? tbl_next : '0,
    rel_branch:    rel,
    branch_offset: branch_offset,
    target:        target,
    fast_shadow:   fast_shadow,
    src_ofs:       src_ofs,
    dst_ofs:       dst_ofs
  };

  // ==========================================================
  // registered field outputs
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fields_o       <= '0;
      fields_valid_o <= 1'b0;
    end
    else
    begin
      fields_valid_o <= publish_tick && ready;
      if (publish_tick && ready)
        fields_o <= next_fields;
    end
  end

  // ==========================================================
  // alu status flags
  ofd_status_t next_status;
  assign next_status = (status_o & ~alu_flag_we_i) | (alu_flags_i & alu_flag_we_i);

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      status_o <= '0;
    else
      status_o <= next_status;
  end
endmodule

/* File: test/ofd_decoder_asserts.sv */
// Checker for the operand field decoder, watching its top ports only.
// Assumes OSC_DIV of 1, so the phase advances on every clock.
`timescale 1ns/1ps
module ofd_decoder_checker
#(
  parameter int OSC_DIV = 1
)
(
  input wire logic                       clk_sys_i,
  input wire logic                       rst_b_i,
  input wire logic                       instr_valid_i,
  input wire logic [ofd_pkg::WORD_W-1:0] instr_word_i,
  input wire ofd_pkg::ofd_fmt_t          instr_fmt_i,
  input wire logic [ofd_pkg::BANK_W-1:0] bank_select_reg_i,
  input wire logic [ofd_pkg::TBLP_W-1:0] program_table_pointer_i,
  input wire ofd_pkg::ofd_status_t       alu_flags_i,
  input wire ofd_pkg::ofd_status_t       alu_flag_we_i,
  input wire ofd_pkg::ofd_fields_t       fields_o,
  input wire logic                       fields_valid_o,
  input wire ofd_pkg::ofd_phase_t        phase_o,
  input wire logic                       second_wait_o,
  input wire ofd_pkg::ofd_status_t       status_o
);
  import ofd_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // word takes
  sequence s_take;
    instr_valid_i && phase_o == OFD_Q1 && instr_word_i[15:12] != SECOND_TAG;
  endsequence
  sequence s_take_one;
    s_take ##0 !second_wait_o && instr_fmt_i inside {OFD_FMT_BYTE, OFD_FMT_BIT,
      OFD_FMT_LIT8, OFD_FMT_BRA11, OFD_FMT_BR8, OFD_FMT_TBL, OFD_FMT_RET};
  endsequence
  sequence s_take_pair;
    s_take ##0 !second_wait_o && instr_fmt_i inside {OFD_FMT_MOVFF, OFD_FMT_GOTO,
      OFD_FMT_CALL, OFD_FMT_LFSR, OFD_FMT_MOVSF, OFD_FMT_MOVSS};
  endsequence
  // ==========================================================
  // timing and fields
  a_phase_rotate: assert property (rst_b_i |=>
    phase_o == {$past(phase_o[2:0]), $past(phase_o[3])}) else $error("phase order wrong");
  a_publish_phase: assert property (fields_valid_o |->
    phase_o == OFD_Q1 && $past(phase_o) == OFD_Q4) else $error("publish off phase");
  a_single_publish: assert property (s_take_one |=>
    !fields_valid_o [*3] ##1 fields_valid_o) else $error("single word not published");
  a_pair_wait: assert property (s_take_pair |=>
    second_wait_o [*4] ##1 !second_wait_o ##3 fields_valid_o) else $error("pair wrong");
  a_status_write: assert property ($past(rst_b_i) |-> status_o ==
    (($past(alu_flag_we_i) & $past(alu_flags_i)) | (~$past(alu_flag_we_i) & $past(status_o))))
    else $error("status flag update wrong");
  a_fields_hold: assert property ($past(rst_b_i) && !fields_valid_o |->
    $stable(fields_o)) else $error("fields changed without publish");
  a_bit_mask: assert property (fields_valid_o && fields_o.fmt == OFD_FMT_BIT |->
    fields_o.bit_mask == (BIT_ONE << fields_o.bit_num)) else $error("bit mask wrong");
  a_access_bank: assert property (fields_valid_o && fields_o.access_ram |->
    fields_o.bank == 4'h0) else $error("bank used in access ram");
  a_nop_format: assert property (fields_valid_o && fields_o.is_nop |->
    fields_o.fmt == OFD_FMT_NOP && fields_o.literal == '0 && !fields_o.rel_branch &&
    !fields_o.fast_shadow && !fields_o.to_file && fields_o.file_addr == '0)
    else $error("nop format wrong");
  a_tbl_preinc: assert property (fields_valid_o && fields_o.fmt == OFD_FMT_TBL
    && fields_o.tbl_mode == OFD_TBL_PRE_INC |-> fields_o.tbl_addr == fields_o.tbl_ptr_next)
    else $error("pre increment address wrong");
endmodule

bind ofd_decoder ofd_decoder_checker #(.OSC_DIV(OSC_DIV)) i_ofd_decoder_checker (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
  .instr_word_i(instr_word_i), .instr_fmt_i(instr_fmt_i),
  .bank_select_reg_i(bank_select_reg_i), .program_table_pointer_i(program_table_pointer_i),
  .alu_flags_i(alu_flags_i), .alu_flag_we_i(alu_flag_we_i), .fields_o(fields_o),
  .fields_valid_o(fields_valid_o), .phase_o(phase_o), .second_wait_o(second_wait_o),
  .status_o(status_o));

/* File: test/ofd_fetch_model.sv */
// Fetch model: offers one requested word at the phase-one edge.
// Assumes OSC_DIV of 1; released word lines show the inverted last word.
`timescale 1ns/1ps
module ofd_fetch_model
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  input  wire ofd_pkg::ofd_phase_t  phase_i,
  input  wire logic                 req_i,
  input  wire logic [15:0]          word_i,
  input  wire ofd_pkg::ofd_fmt_t    fmt_i,
  output logic                      taken_o = 1'b0,
  output logic                      instr_valid_o = 1'b0,
  output logic [15:0]               instr_word_o = 16'h0000,
  output ofd_pkg::ofd_fmt_t         instr_fmt_o = ofd_pkg::OFD_FMT_NOP
);
  import ofd_pkg::*;
  // one word per instruction cycle
  always @(negedge clk_sys_i)
    if (rst_b_i && req_i && phase_i == OFD_Q1 && !instr_valid_o)
    begin
      instr_valid_o <= 1'b1;
      instr_word_o  <= word_i;
      instr_fmt_o   <= fmt_i;
    end
    else
    begin
      instr_valid_o <= 1'b0;
      instr_word_o  <= ~instr_word_o;
      instr_fmt_o   <= ofd_fmt_t'(~instr_fmt_o);
    end
  always @(posedge clk_sys_i)
    taken_o <= instr_valid_o;
endmodule

/* File: test/test_ofd_decoder.sv */
// Self-checking bench for the operand field decoder.
// Assumes OSC_DIV of 1; the fetch model presents words at phase one.
`timescale 1ns/1ps
module test_ofd_decoder;
  import ofd_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        req       = 1'b0;
  logic [15:0] rq_word   = 16'h0000;
  ofd_fmt_t    rq_fmt    = OFD_FMT_BYTE;
  logic [3:0]  bank_sel  = 4'h0;
  logic [20:0] ptr       = 21'h00_0000;
  ofd_status_t flags     = '0;
  ofd_status_t flag_we   = '0;
  ofd_status_t exp_st    = '0;
  logic [31:0] seed      = 32'h0000_0010;
  logic        taken, iv, fv, sw;
  logic [15:0] iw;
  ofd_fmt_t    ifm;
  ofd_fields_t fo;
  ofd_phase_t  ph;
  ofd_status_t st;
  int          errors = 0;
  int          checks = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  ofd_fetch_model i_ofd_fetch_model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .phase_i(ph), .req_i(req), .word_i(rq_word), .fmt_i(rq_fmt), .taken_o(taken),
    .instr_valid_o(iv), .instr_word_o(iw), .instr_fmt_o(ifm));
  ofd_decoder #(.OSC_DIV(1)) i_ofd_decoder (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .instr_valid_i(iv), .instr_word_i(iw), .instr_fmt_i(ifm), .bank_select_reg_i(bank_sel),
    .program_table_pointer_i(ptr), .alu_flags_i(flags), .alu_flag_we_i(flag_we),
    .fields_o(fo), .fields_valid_o(fv), .phase_o(ph), .second_wait_o(sw), .status_o(st));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_st(input ofd_status_t e, input ofd_status_t g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH status expected %h seen %h", e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_for(input bit pub);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while ((pub ? fv : taken) !== 1'b1 && n < 20);
    if ((pub ? fv : taken) !== 1'b1)
    begin
      errors++;
      end_sim();
    end
  endtask
  // ==========================================================
  // one instruction: send, await publish, compare fields
  task automatic run(input ofd_fmt_t f, input logic [15:0] w1, input logic [15:0] w2,
                     input logic [20:0] p);
    logic        two, nop;
    logic [1:0]  m;
    logic [20:0] nx;
    two = f inside {OFD_FMT_MOVFF, OFD_FMT_GOTO, OFD_FMT_CALL, OFD_FMT_LFSR,
                    OFD_FMT_MOVSF, OFD_FMT_MOVSS};
    nop = (two && w2[15:12] != SECOND_TAG) || w1[15:12] == SECOND_TAG;
    bank_sel = 4'(rnd());
    ptr = p;
    rq_word <= w1;
    rq_fmt <= f;
    req <= 1'b1;
    wait_for(0);
    chk("wait", two && w1[15:12] != SECOND_TAG, sw);
    if (two)
    begin
      rq_word <= w2;
      wait_for(0);
    end
    req <= 1'b0;
    wait_for(1);
    chk("phase", OFD_Q1, ph);
    m = w1[1:0];
    nx = m == 2'h2 ? p - 21'h1 : (m[0] ? p + 21'h1 : p);
    chk("fmt", nop ? OFD_FMT_NOP : f, fo.fmt);
    chk("is_nop", nop, fo.is_nop);
    if (!nop)
      case (f)
        OFD_FMT_BYTE, OFD_FMT_BIT:
        begin
          chk("access", !w1[8], fo.access_ram);
          chk("bank", w1[8] ? bank_sel : 4'h0, fo.bank);
          chk("file", w1[7:0], fo.file_addr);
          if (f == OFD_FMT_BYTE)
            chk("to_file", w1[9], fo.to_file);
          else
            chk("bit", {w1[11:9], 8'h01 << w1[11:9]}, {fo.bit_num, fo.bit_mask});
        end
        OFD_FMT_LIT8: chk("lit", {w1[7:0], OFD_LIT_8}, {fo.literal, fo.lit_width});
        OFD_FMT_LFSR:
        begin
          chk("lit", {w1[3:0], w2[7:0], OFD_LIT_12}, {fo.literal, fo.lit_width});
          chk("ptr", w1[5:4], fo.ptr_sel);
        end
        OFD_FMT_MOVFF: chk("addr", {w1[11:0], w2[11:0]}, {fo.src_addr, fo.dst_addr});
        OFD_FMT_MOVSF: chk("dst", w2[11:0], fo.dst_addr);
        OFD_FMT_GOTO, OFD_FMT_CALL:
        begin
          chk("lit", {w2[11:0], w1[7:0], OFD_LIT_20}, {fo.literal, fo.lit_width});
          chk("target", {w2[11:0], w1[7:0], 1'b0}, {fo.target, fo.rel_branch});
          chk("fast", f == OFD_FMT_CALL && w1[8], fo.fast_shadow);
        end
        OFD_FMT_RET: chk("fast", w1[0], fo.fast_shadow);
        OFD_FMT_BRA11: chk("ofs", {1'b1, {10{w1[10]}}, w1[10:0]},
                           {fo.rel_branch, fo.branch_offset});
        OFD_FMT_BR8: chk("ofs", {1'b1, {13{w1[7]}}, w1[7:0]},
                         {fo.rel_branch, fo.branch_offset});
        OFD_FMT_TBL:
        begin
          chk("tbl", {m, m == 2'h3 ? nx : p}, {fo.tbl_mode, fo.tbl_addr});
          chk("next", nx, fo.tbl_ptr_next);
        end
        OFD_FMT_MOVSS: chk("ofs", {w1[6:0], w2[6:0]}, {fo.src_ofs, fo.dst_ofs});
        default: ;
      endcase
  endtask

  // ==========================================================
  // status flags: random writes every cycle
  always @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
      exp_st <= '0;
    else
      exp_st <= (flag_we & flags) | (~flag_we & exp_st);
  always @(negedge clk_sys_i)
    if (rst_b_i)
    begin
      chk_st(exp_st, st);
      {flags, flag_we} = 10'(rnd());
    end

  initial
  begin
    repeat (16) @(negedge clk_sys_i);
    rst_b_i <= 1'b1;
    run(OFD_FMT_BIT, 16'h0EFF, 16'h0000, 21'h00_0000);
    for (int m = 0; m < 4; m++)
    begin
      run(OFD_FMT_TBL, 16'(m), 16'h0000, 21'h1F_FFFF);
      run(OFD_FMT_TBL, 16'(m), 16'h0000, 21'h00_0000);
    end
    run(OFD_FMT_BRA11, 16'h0400, 16'h0000, 21'h00_0000);
    run(OFD_FMT_BR8, 16'h0080, 16'h0000, 21'h00_0000);
    run(OFD_FMT_CALL, 16'h01FF, 16'hFFFF, 21'h00_0000);
    run(OFD_FMT_RET, 16'h0001, 16'h0000, 21'h00_0000);
    run(OFD_FMT_GOTO, 16'h00AB, 16'h1234, 21'h00_0000);
    run(OFD_FMT_BYTE, 16'hF123, 16'h0000, 21'h00_0000);
    $display("corner tests done, errors %0d", errors);
    for (int i = 0; i < 80; i++)
      run(ofd_fmt_t'(4'(rnd() % 13) + 4'h1), {1'b0, 15'(rnd())},
          {SECOND_TAG, 12'(rnd())}, 21'(rnd()));
    $display("random tests done, errors %0d", errors);
    end_sim();
  end
endmodule
